// ==== rief_pkg.sv ====
// rief_pkg: constants for the counter interrupt enable/flag block
// assumes one 250 MHz system clock; byte-wide registers on a plain port
package rief_pkg;
  localparam int        ADDR_W         = 4;
  localparam int        DATA_W         = 8;
  localparam logic [3:0] OFF_ENABLE_CLR = 4'h6;
  localparam logic [3:0] OFF_ENABLE_SET = 4'h7;
  localparam logic [3:0] OFF_FLAGS      = 4'h8;
  localparam logic [3:0] OFF_STATUS     = 4'ha;
  localparam logic [3:0] OFF_MODE       = 4'hb;
  localparam int        BIT_OVF        = 7;
  localparam int        BIT_SYNC       = 6;
  localparam int        BIT_CMP1       = 1;
  localparam int        BIT_COMPARE_ZERO_HIT       = 0;
  localparam logic [7:0] ENABLE_RESET   = 8'h00;
  localparam logic [7:0] FLAGS_RESET    = 8'h00;
  localparam logic [1:0] MODE_RESET     = 2'h0;
  localparam logic [7:0] MASK_SINGLE    = 8'hc1;
  localparam logic [7:0] MASK_DUAL      = 8'hc3;
  typedef enum logic [1:0] {
    RIEF_COUNT32,
    RIEF_COUNT16,
    RIEF_CALENDAR
  } rief_mode_type;
endpackage : rief_pkg

// ==== rief_irq.sv ====
// rief_irq: interrupt enable set/clear and flag registers of a real-time counter
// assumes event and sync inputs are single-cycle pulses already on sys_clk, so they
// pass no synchroniser here; the counter-clock crossing is done upstream
//
// Operation
// R1: writing one to set-enable bit sets that interrupt enable
// R2: writing one to clear-enable bit clears that interrupt enable
// R3: in calendar mode clear-enable bit 0 disables the alarm interrupt
// R4: writing zero to enable or flag bits changes nothing
// R5: interrupt request raised while a flag and its enable are both one
// R6: overflow flag bit 7 set the cycle after a counter overflow
// R7: sync-ready flag set when busy falls, unless from enable or soft reset
// R8: compare flags set the cycle after a compare match in counter modes
// R9: alarm flag bit 0 set the cycle after a calendar alarm match
// R10: writing one to a flag bit clears that flag
// R11: overflow at bit 7, sync-ready bit 6, compare/alarm bits 1 and 0
// R12: enable bits reset to zero
// R13: flag bits reset to zero
// R14: busy status set when synchronisation starts, cleared when it completes
// R15: both enable views read the same enable state
// R16: a flag set and cleared in one cycle ends up set
//
// Added by the designer: the address-and-strobe port.
`timescale 1ns/10ps
module rief_irq
  import rief_pkg::*;
#(
  parameter int ADDR_BITS = rief_pkg::ADDR_W
)
(
  input  wire logic                  sys_clk,
  input  wire logic                  resetn,
  input  wire logic [ADDR_BITS-1:0]  regAddr,
  input  wire logic [7:0]            regWdata,
  input  wire logic                  regWrite,
  input  wire logic                  regRead,
  output logic      [7:0]            regRdata,
  input  wire logic                  counterOverflow,
  input  wire logic [1:0]            compareHit,
  input  wire logic                  alarmZeroHit,
  input  wire logic                  syncStart,
  input  wire logic                  syncDone,
  input  wire logic                  syncCauseEnable,
  output logic                       syncInProgress,
  output logic                       irqOut
);
  import rief_pkg::*;

  initial
  begin
    if (ADDR_BITS < 4) $error("ADDR_BITS must be at least 4");
  end

  // reset release through two flops; assert is async, release is clocked
  // a clocked release keeps every register leaving reset on the same edge,
  // which an unsynchronised release near a clock edge cannot promise
  logic rstMeta_r;
  logic rstSync_r;
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      rstMeta_r <= 1'b0;
      rstSync_r <= 1'b0;
    end
    else
    begin
      rstMeta_r <= 1'b1;
      rstSync_r <= rstMeta_r;
    end
  end
  wire rstn = rstSync_r;

  // implemented bit mask depends on mode; unused bits read zero
  function automatic logic [7:0] modeMask(input logic [1:0] m);
    modeMask = (m == 2'(RIEF_COUNT16)) ? MASK_DUAL : MASK_SINGLE; // R11
  endfunction : modeMask

  // decode of a write to a given offset
  function automatic logic hitWrite(input logic we, input logic [ADDR_BITS-1:0] a,
                                    input logic [3:0] off);
    hitWrite = we && (a == ADDR_BITS'(off));
  endfunction : hitWrite

  logic [1:0]  mode_r;
  logic [7:0]  enable_r;
  logic [7:0]  enable_nxt;
  logic [7:0]  flags_r;
  logic [7:0]  flags_nxt;
  logic [7:0]  hwSet;
  logic [7:0]  mask;
  logic        busy_r;
  logic        busyPrev_r;
  logic        causeLatched_r;
  logic        syncFall;

  assign mask = modeMask(mode_r);

  // mode selector register; changing it drops only bit 1 of flags and enables when leaving the 16-bit mode, software should flush the rest
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
      mode_r <= MODE_RESET;
    else if (hitWrite(regWrite, regAddr, OFF_MODE) && regWdata[1:0] != 2'h3)
      mode_r <= regWdata[1:0];
  end

  // enables: set view ors in ones, clear view masks them out; zeros no effect
  always_comb
  begin
    enable_nxt = enable_r;
    if (hitWrite(regWrite, regAddr, OFF_ENABLE_SET))
      enable_nxt = enable_r | (regWdata & mask); // R1 R4
    if (hitWrite(regWrite, regAddr, OFF_ENABLE_CLR))
      enable_nxt = enable_r & ~regWdata; // R2 R3 R4
  end

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
      enable_r <= ENABLE_RESET; // R12
    else
      enable_r <= enable_nxt & mask;
  end

  // busy status: set on start, cleared on completion; start wins a tie
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
      busy_r <= 1'b0;
    else if (syncStart)
      busy_r <= 1'b1; // R14
    else if (syncDone)
      busy_r <= 1'b0; // R14
  end

  // remember whether the current sync was launched by enable or soft reset
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      busyPrev_r     <= 1'b0;
      causeLatched_r <= 1'b0;
    end
    else
    begin
      busyPrev_r <= busy_r;
      if (syncStart)
        causeLatched_r <= syncCauseEnable;
    end
  end

  assign syncFall = busyPrev_r && !busy_r && !causeLatched_r; // R7

  // hardware set vector; events already registered one cycle in the counter domain
  always_comb
  begin
    hwSet           = 8'h00;
    hwSet[BIT_OVF]  = counterOverflow; // R6
    hwSet[BIT_SYNC] = syncFall; // R7
    if (mode_r == 2'(RIEF_CALENDAR))
      hwSet[BIT_COMPARE_ZERO_HIT] = alarmZeroHit; // R9
    else
    begin
      hwSet[BIT_COMPARE_ZERO_HIT] = compareHit[0]; // R8
      if (mode_r == 2'(RIEF_COUNT16))
        hwSet[BIT_CMP1] = compareHit[1]; // R8
    end
  end

  // flags: write-one clears, hardware set wins over a same-cycle clear
  always_comb
  begin
    flags_nxt = flags_r;
    if (hitWrite(regWrite, regAddr, OFF_FLAGS))
      flags_nxt = flags_r & ~regWdata; // R10 R4
    flags_nxt = (flags_nxt | hwSet) & mask; // R16
  end

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
      flags_r <= FLAGS_RESET; // R13
    else
      flags_r <= flags_nxt;
  end

  // level interrupt, combinational from registered state
  assign irqOut         = |(flags_r & enable_r); // R5
  assign syncInProgress = busy_r;

  // read data valid only in the cycle after the strobe, zero otherwise
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
      regRdata <= 8'h00;
    else if (regRead)
    begin
      case (regAddr)
        ADDR_BITS'(OFF_ENABLE_CLR): regRdata <= enable_r; // R15
        ADDR_BITS'(OFF_ENABLE_SET): regRdata <= enable_r; // R15
        ADDR_BITS'(OFF_FLAGS):      regRdata <= flags_r;
        ADDR_BITS'(OFF_STATUS):     regRdata <= {busy_r, 7'h00};
        ADDR_BITS'(OFF_MODE):       regRdata <= {6'h00, mode_r};
        default:                    regRdata <= 8'h00;
      endcase
    end
    else
      regRdata <= 8'h00;
  end

  // assertions: all on sys_clk and gated by the synchronised reset, so the
  // two release edges never see half-updated registers

  // a set-enable write makes every written one in an implemented bit visible next cycle
  AST_SET_EN: assert property (@(posedge sys_clk) disable iff (!rstn) // R1
    hitWrite(regWrite, regAddr, OFF_ENABLE_SET)
      |=> ((enable_r & $past(regWdata & mask)) == $past(regWdata & mask)))
    else $error("set-enable write did not set enable");

  // a clear-enable write removes every written one
  AST_CLR_EN: assert property (@(posedge sys_clk) disable iff (!rstn) // R2
    hitWrite(regWrite, regAddr, OFF_ENABLE_CLR) |=> ((enable_r & $past(regWdata)) == 8'h00))
    else $error("clear-enable write did not clear enable");

  // calendar alarm enable goes away on a clear of bit 0
  AST_CAL_ALARM_OFF: assert property (@(posedge sys_clk) disable iff (!rstn) // R3
    (mode_r == 2'(RIEF_CALENDAR)) && hitWrite(regWrite, regAddr, OFF_ENABLE_CLR) && regWdata[0]
      |=> !enable_r[BIT_COMPARE_ZERO_HIT])
    else $error("alarm enable not cleared");

  // zero written to the set view leaves enables alone
  AST_ZERO_NOP: assert property (@(posedge sys_clk) disable iff (!rstn) // R4
    hitWrite(regWrite, regAddr, OFF_ENABLE_SET) && regWdata == 8'h00 && $stable(mode_r)
      |=> $stable(enable_r))
    else $error("zero write changed enables");

  // zero written to the clear view leaves enables alone
  AST_ZERO_CLR_NOP: assert property (@(posedge sys_clk) disable iff (!rstn) // R4
    hitWrite(regWrite, regAddr, OFF_ENABLE_CLR) && regWdata == 8'h00 && $stable(mode_r)
      |=> $stable(enable_r))
    else $error("zero clear write changed enables");

  // zero written to the flags clears none of them
  AST_ZERO_FLAG_NOP: assert property (@(posedge sys_clk) disable iff (!rstn) // R4
    hitWrite(regWrite, regAddr, OFF_FLAGS) && regWdata == 8'h00 && $stable(mode_r)
      |=> ((flags_r & $past(flags_r)) == $past(flags_r)))
    else $error("zero write cleared a flag");

  // interrupt line follows flags and enables
  AST_IRQ: assert property (@(posedge sys_clk) disable iff (!rstn) // R5
    irqOut == |(flags_r & enable_r))
    else $error("interrupt line mismatch");

  // overflow event lands in bit 7 next cycle
  AST_OVF_SET: assert property (@(posedge sys_clk) disable iff (!rstn) // R6
    counterOverflow |=> flags_r[BIT_OVF])
    else $error("overflow flag not set");

  // busy fall not caused by enable or soft reset raises sync-ready
  AST_SYNC_SET: assert property (@(posedge sys_clk) disable iff (!rstn) // R7
    $fell(busy_r) && !causeLatched_r |=> flags_r[BIT_SYNC])
    else $error("sync-ready not raised on busy fall");

  // busy fall from enable or soft reset must not raise sync-ready
  AST_SYNC_QUIET: assert property (@(posedge sys_clk) disable iff (!rstn) // R7
    $fell(busy_r) && causeLatched_r && !flags_r[BIT_SYNC] |=> !flags_r[BIT_SYNC])
    else $error("sync-ready raised by enable sync");

  // compare 0 match sets bit 0 in both counter modes
  AST_CMP_SET: assert property (@(posedge sys_clk) disable iff (!rstn) // R8
    (mode_r != 2'(RIEF_CALENDAR)) && compareHit[0] |=> flags_r[BIT_COMPARE_ZERO_HIT])
    else $error("compare flag not set");

  // compare 1 match sets bit 1 only in the 16-bit mode
  AST_CMP1_SET: assert property (@(posedge sys_clk) disable iff (!rstn) // R8
    (mode_r == 2'(RIEF_COUNT16)) && compareHit[1] |=> flags_r[BIT_CMP1])
    else $error("compare 1 flag not set");

  // calendar alarm match sets bit 0
  AST_ALARM_SET: assert property (@(posedge sys_clk) disable iff (!rstn) // R9
    (mode_r == 2'(RIEF_CALENDAR)) && alarmZeroHit |=> flags_r[BIT_COMPARE_ZERO_HIT])
    else $error("alarm flag not set");

  // write one clears overflow when no new event competes
  AST_FLAG_CLR: assert property (@(posedge sys_clk) disable iff (!rstn) // R10
    hitWrite(regWrite, regAddr, OFF_FLAGS) && regWdata[BIT_OVF] && !counterOverflow
      |=> !flags_r[BIT_OVF])
    else $error("flag not cleared by write one");

  // write one clears bit 0 when no match competes
  AST_FLAG_CLR_LOW: assert property (@(posedge sys_clk) disable iff (!rstn) // R10
    hitWrite(regWrite, regAddr, OFF_FLAGS) && regWdata[BIT_COMPARE_ZERO_HIT] && !compareHit[0]
      && !alarmZeroHit |=> !flags_r[BIT_COMPARE_ZERO_HIT])
    else $error("bit 0 flag not cleared by write one");

  // write one clears sync-ready when no fall competes
  AST_SYNC_CLR: assert property (@(posedge sys_clk) disable iff (!rstn) // R10
    hitWrite(regWrite, regAddr, OFF_FLAGS) && regWdata[BIT_SYNC] && !syncFall
      |=> !flags_r[BIT_SYNC])
    else $error("sync-ready not cleared by write one");

  // bits 5 to 2 never implemented
  AST_LAYOUT: assert property (@(posedge sys_clk) disable iff (!rstn) // R11
    ((flags_r | enable_r) & 8'h3c) == 8'h00)
    else $error("unimplemented bit set");

  // bit 1 exists only in the 16-bit mode once the mode has settled
  AST_LAYOUT_BIT1: assert property (@(posedge sys_clk) disable iff (!rstn) // R11
    (mode_r != 2'(RIEF_COUNT16)) && $stable(mode_r)
      |-> !flags_r[BIT_CMP1] && !enable_r[BIT_CMP1])
    else $error("bit 1 set outside 16-bit mode");

  // busy rises after a start
  AST_BUSY: assert property (@(posedge sys_clk) disable iff (!rstn) // R14
    syncStart |=> busy_r)
    else $error("busy not set on sync start");

  // busy falls after a completion with no new start
  AST_BUSY_CLR: assert property (@(posedge sys_clk) disable iff (!rstn) // R14
    syncDone && !syncStart |=> !busy_r)
    else $error("busy not cleared on sync done");

  // status read returns busy in bit 7
  AST_RD_STATUS: assert property (@(posedge sys_clk) disable iff (!rstn) // R14
    regRead && regAddr == ADDR_BITS'(OFF_STATUS) |=> regRdata == {$past(busy_r), 7'h00})
    else $error("status read mismatch");

  // both enable views read the same enable state
  AST_RD_ENABLE: assert property (@(posedge sys_clk) disable iff (!rstn) // R15
    regRead && (regAddr == ADDR_BITS'(OFF_ENABLE_CLR) || regAddr == ADDR_BITS'(OFF_ENABLE_SET))
      |=> regRdata == $past(enable_r))
    else $error("enable read mismatch");

  // flag read returns the flags of the strobe cycle
  AST_RD_FLAGS: assert property (@(posedge sys_clk) disable iff (!rstn) // R10
    regRead && regAddr == ADDR_BITS'(OFF_FLAGS) |=> regRdata == $past(flags_r))
    else $error("flag read mismatch");

  // read data stand only in the cycle after a strobe
  AST_RD_IDLE: assert property (@(posedge sys_clk) disable iff (!rstn)
    !regRead |=> regRdata == 8'h00)
    else $error("read data not zero when idle");

  // mode value 3 is refused
  AST_MODE_HOLD: assert property (@(posedge sys_clk) disable iff (!rstn)
    hitWrite(regWrite, regAddr, OFF_MODE) && regWdata[1:0] == 2'h3 |=> $stable(mode_r))
    else $error("refused mode value taken");

  // overflow set beats a same-cycle clear
  AST_SET_WINS: assert property (@(posedge sys_clk) disable iff (!rstn) // R16
    counterOverflow && hitWrite(regWrite, regAddr, OFF_FLAGS) |=> flags_r[BIT_OVF])
    else $error("set lost to clear");

  // sync-ready set beats a same-cycle clear
  AST_SET_WINS_SYNC: assert property (@(posedge sys_clk) disable iff (!rstn) // R16
    syncFall && hitWrite(regWrite, regAddr, OFF_FLAGS) |=> flags_r[BIT_SYNC])
    else $error("sync-ready set lost to clear");
endmodule : rief_irq

// ==== rief_irq_bench.sv ====
// rief_irq_bench: self-checking bench for the interrupt enable/flag block
// assumes rief_pkg offsets; the bench drives every port itself at the rising edge
`timescale 1ns/10ps
module rief_irq_bench;
  import rief_pkg::*;
  logic       sys_clk, resetn, regWrite, regRead, irqOut, syncInProgress;
  logic [3:0] regAddr;
  logic [7:0] regWdata, regRdata;
  logic       counterOverflow, alarmZeroHit, syncStart, syncDone, syncCauseEnable;
  logic [1:0] compareHit;
  int         error_cnt, n_tests, cycles, r;
  logic [7:0] en, fl;
  logic [1:0] md;
  logic       busy, cause;
  logic [6:0] evm;

  rief_irq rief_irq_inst (.sys_clk(sys_clk), .resetn(resetn), .regAddr(regAddr),
    .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
    .counterOverflow(counterOverflow), .compareHit(compareHit), .alarmZeroHit(alarmZeroHit),
    .syncStart(syncStart), .syncDone(syncDone), .syncCauseEnable(syncCauseEnable),
    .syncInProgress(syncInProgress), .irqOut(irqOut));

  // 250 MHz clock
  initial
  begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  task report_and_stop;
    if (error_cnt == 0 && n_tests > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : report_and_stop

  // a hang is cut short well past the few hundred cycles the tests need
  always @(posedge sys_clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      error_cnt++;
      report_and_stop();
    end
  end

  task chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  function logic [7:0] msk(input logic [1:0] m);
    return (m == 2'h1) ? MASK_DUAL : MASK_SINGLE;
  endfunction : msk

  // one cycle of stimulus; ev = {ovf, cmp1, compare_zero_hit, alarm, start, done, cause}
  // the model is advanced at once, reads in checkall come only after an idle cycle
  task step(input logic w, input logic rd, input logic [3:0] a, input logic [7:0] d,
            input logic [6:0] ev);
    @(posedge sys_clk);
    regWrite <= w;
    regRead  <= rd;
    regAddr  <= a;
    regWdata <= d;
    {counterOverflow, compareHit, alarmZeroHit, syncStart, syncDone, syncCauseEnable} <= ev;
    if (w && a == OFF_FLAGS) fl = fl & ~d;
    fl = fl | ({ev[6], 5'h00, ev[5], ev[4] | ev[3]} & msk(md));
    if (w && a == OFF_ENABLE_SET) en = en | (d & msk(md));
    if (w && a == OFF_ENABLE_CLR) en = en & ~d;
    if (w && a == OFF_MODE && d[1:0] != 2'h3)
    begin
      md = d[1:0];
      en = en & msk(md);
      fl = fl & msk(md);
    end
    if (ev[2])
    begin
      busy  = 1'b1;
      cause = ev[0];
    end
    else if (ev[1] && busy)
    begin
      busy = 1'b0;
      if (!cause) fl = fl | 8'h40;
    end
  endtask : step

  // read data stand only in the cycle after the strobe, so sample just after that edge
  task rdc(input logic [3:0] a, input logic [7:0] exp, input string nm);
    step(1'b0, 1'b1, a, 8'h00, 7'h00);
    step(1'b0, 1'b0, a, 8'h00, 7'h00);
    #1;
    chk(nm, regRdata, exp);
  endtask : rdc

  task checkall;
    step(1'b0, 1'b0, 4'h0, 8'h00, 7'h00);
    rdc(OFF_ENABLE_SET, en, "enable_set");
    rdc(OFF_ENABLE_CLR, en, "enable_clr");
    rdc(OFF_FLAGS, fl, "flags");
    chk("irq", {7'h00, irqOut}, {7'h00, |(fl & en)});
    chk("busy_pin", {7'h00, syncInProgress}, {7'h00, busy});
  endtask : checkall

  initial
  begin
    {resetn, regWrite, regRead, regAddr, regWdata} = '0;
    {counterOverflow, compareHit, alarmZeroHit, syncStart, syncDone, syncCauseEnable} = '0;
    {error_cnt, n_tests, cycles} = '0;
    {en, fl, md, busy, cause} = '0;
    repeat (8) @(posedge sys_clk);
    resetn <= 1'b1;
    repeat (2) @(posedge sys_clk);
    void'($urandom(10));
    rdc(OFF_ENABLE_SET, 8'h00, "enable_reset");
    rdc(OFF_FLAGS, 8'h00, "flags_reset");
    rdc(4'h3, 8'h00, "unmapped");
    for (int m = 0; m < 3; m++)
    begin
      step(1'b1, 1'b0, OFF_MODE, 8'(m), 7'h00);
      evm = (m == 0) ? 7'h50 : (m == 1) ? 7'h70 : 7'h48;
      step(1'b1, 1'b0, OFF_ENABLE_SET, 8'hff, 7'h00);
      step(1'b1, 1'b0, OFF_ENABLE_SET, 8'h00, evm);
      checkall();
      step(1'b1, 1'b0, OFF_FLAGS, 8'h00, 7'h00);
      step(1'b1, 1'b0, OFF_FLAGS, 8'h80, 7'h40);
      step(1'b1, 1'b0, OFF_ENABLE_CLR, 8'h01, 7'h00);
      step(1'b1, 1'b0, 4'h3, 8'hff, 7'h00);
      checkall();
      for (int i = 0; i < 40; i++)
      begin
        r = $urandom;
        step(r[1:0] != 2'h3, 1'b0, 4'h6 + 4'(r[1:0]), r[15:8], r[22:16] & evm);
        if (i % 4 == 3) checkall();
      end
    end
    step(1'b1, 1'b0, OFF_MODE, 8'h03, 7'h00);
    rdc(OFF_MODE, {6'h00, md}, "mode");
    step(1'b0, 1'b0, 4'h0, 8'h00, 7'h04);
    rdc(OFF_STATUS, 8'h80, "busy");
    step(1'b0, 1'b0, 4'h0, 8'h00, 7'h02);
    step(1'b0, 1'b0, 4'h0, 8'h00, 7'h00);
    rdc(OFF_STATUS, 8'h00, "idle");
    checkall();
    step(1'b1, 1'b0, OFF_FLAGS, 8'hff, 7'h05);
    step(1'b0, 1'b0, 4'h0, 8'h00, 7'h02);
    step(1'b0, 1'b0, 4'h0, 8'h00, 7'h00);
    checkall();
    report_and_stop();
  end
endmodule : rief_irq_bench
